// file: verilog/uard_pkg.sv
// Shared constants and types of the asynchronous receiver block.
// Assumes a 40 MHz ref_clk and an AXI4-Lite master with 32-bit data.
`default_nettype none

package uard_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 12;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h0C;
  localparam logic [7:0] IDX_RX_STATUS   = 8'h18;
  localparam logic [7:0] IDX_RX_BUFFER   = 8'h1A;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_TX_STATUS   = 8'h98;
  localparam logic [7:0] IDX_BAUD_DIV    = 8'h99;

  localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS   = {2'h0, IDX_IRQ_FLAGS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RX_STATUS   = {2'h0, IDX_RX_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RX_BUFFER   = {2'h0, IDX_RX_BUFFER, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLES =
    {2'h0, IDX_IRQ_ENABLES, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_TX_STATUS   = {2'h0, IDX_TX_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_BAUD_DIV    = {2'h0, IDX_BAUD_DIV, 2'h0};

  // ==========================================================
  // Field positions
  localparam int BIT_RX_FLAG    = 5;  // irq flags and enables
  localparam int BIT_PORT_EN    = 7;  // receive status/control
  localparam int BIT_NINE_EN    = 6;
  localparam int BIT_SINGLE_RX  = 5;
  localparam int BIT_CONT_RX    = 4;
  localparam int BIT_ADDR_DET   = 3;
  localparam int BIT_FRAME_ERR  = 2;
  localparam int BIT_OVERRUN    = 1;
  localparam int BIT_NINTH      = 0;
  localparam int BIT_SYNC_MODE  = 4;  // transmit status/control
  localparam int BIT_HIGH_BAUD  = 2;
  localparam int BIT_TX_EMPTY   = 1;

  // ==========================================================
  // Reset values and masks
  localparam logic [7:0] RST_IRQ_ENABLES = 8'h00;
  localparam logic [7:0] RST_RX_CTRL     = 8'h00;
  localparam logic [7:0] RST_TX_STATUS   = 8'h02;
  localparam logic [7:0] RST_BAUD_DIV    = 8'h00;
  localparam logic [7:0] MASK_RX_CTRL    = 8'hF8;
  localparam logic [7:0] MASK_TX_STATUS  = 8'hFD;

  // ==========================================================
  // Sampling: sixteen ticks per bit, vote on ticks 7, 8 and 9
  localparam int          OVERSAMPLE  = 16;
  localparam int          LOW_PRESCALE = 4;
  localparam logic [3:0]  TICK_S1     = 4'h7;
  localparam logic [3:0]  TICK_S2     = 4'h8;
  localparam logic [3:0]  TICK_VOTE   = 4'h9;
  localparam logic [3:0]  BITS_EIGHT  = 4'h8;
  localparam logic [3:0]  BITS_NINE   = 4'h9;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } uard_rx_state_e;

  typedef struct packed {
    logic       frameErr;
    logic       ninth;
    logic [7:0] data;
  } uard_word_s;

endpackage : uard_pkg

`default_nettype wire

// file: verilog/uard_baud_gen.sv
// Baud generator giving a one-cycle tick at sixteen times the bit rate.
// Assumes the divisor is stable while the receiver runs.
`timescale 1ns/100ps
`default_nettype none

module uard_baud_gen
  import uard_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // Control
  input  wire logic       run,
  input  wire logic       highBaud,
  input  wire logic [7:0] divisor,
  // Tick out
  output var  logic       sampleTick
);

  logic [7:0] count_q;
  logic [1:0] pre_q;
  logic       lastPre;

  assign lastPre = (pre_q == 2'(LOW_PRESCALE - 1));

  // ==========================================================
  // Divider; held in reload while the receiver is off
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q    <= 8'h00;
      pre_q      <= 2'h0;
      sampleTick <= 1'b0;
    end else if (!run) begin
      count_q    <= divisor;
      pre_q      <= 2'h0;
      sampleTick <= 1'b0;
    end else if (count_q == 8'h00) begin
      count_q <= divisor;
      if (highBaud || lastPre) begin
        pre_q      <= 2'h0;
        sampleTick <= 1'b1;
      end else begin
        pre_q      <= pre_q + 2'h1;
        sampleTick <= 1'b0;
      end
    end else begin
      count_q    <= count_q - 8'h01;
      sampleTick <= 1'b0;
    end
  end

endmodule // uard_baud_gen

`default_nettype wire

// file: verilog/uard_rx_fifo.sv
// Two-entry receive buffer holding data with its ninth bit and framing flag.
// Assumes the writer never pushes while full.
`timescale 1ns/100ps
`default_nettype none

module uard_rx_fifo
  import uard_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // Fill side
  input  wire logic       push,
  input  wire uard_word_s pushWord,
  // Drain side
  input  wire logic       pop,
  output uard_word_s      head,
  output logic            full,
  output logic            empty
);

  uard_word_s mem_q [2];
  logic       wrPtr_q;
  logic       rdPtr_q;
  logic [1:0] count_q;
  logic       doPush;
  logic       doPop;

  assign full   = (count_q == 2'h2);
  assign empty  = (count_q == 2'h0);
  assign doPush = push && !full;
  assign doPop  = pop && !empty;
  assign head   = mem_q[rdPtr_q];

  // ==========================================================
  // Storage and pointers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wrPtr_q  <= 1'b0;
      rdPtr_q  <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      if (doPush) begin
        mem_q[wrPtr_q] <= pushWord;
        wrPtr_q        <= !wrPtr_q;
      end
      if (doPop) begin
        rdPtr_q <= !rdPtr_q;
      end
      count_q <= count_q + {1'b0, doPush} - {1'b0, doPop};
    end
  end

endmodule // uard_rx_fifo

`default_nettype wire

// file: verilog/uard_receiver.sv
// Asynchronous serial receiver with address detect and AXI4-Lite registers.
// Assumes receivePin is asynchronous to ref_clk and idles high.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Pin oversampled sixteen times a bit; shifter advances once per bit.
// - Reception happens only while continuous-receive enable is set.
// - After stop bit, word moves to buffer if room; receive flag set.
// - Interrupt request only when receive interrupt enable is set.
// - Receive flag is read-only; clears when buffer reads leave it empty.
// - Stop bit with buffer full sets overrun and drops the word.
// - Overrun clears only by clearing continuous-receive enable.
// - While overrun is set, no word enters the buffer.
// - Zero stop bit sets the framing-error flag.
// - Framing flag and ninth bit queue with each word.
// - Nine data bits when nine-bit enable set, else eight.
// - Address-detect enable filters frames reaching the buffer in nine-bit mode only.
// - Without address detect, every frame is buffered and flagged unless the buffer is full or overrun is set.
// - Frame: start bit, eight or nine bits LSB first, stop bit.
// - Sample tick is x16 with high baud select, else x64 base.
module uard_receiver
  import uard_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // Serial line
  input  wire logic              receivePin,
  // Interrupt request
  output var  logic              rxIrq,
  // AXI4-Lite write address
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  // AXI4-Lite write data
  input  wire logic              wvalid,
  output var  logic              wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  // AXI4-Lite write response
  output var  logic              bvalid,
  input  wire logic              bready,
  output var  logic [1:0]        bresp,
  // AXI4-Lite read address
  input  wire logic              arvalid,
  output var  logic              arready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  // AXI4-Lite read data
  output var  logic              rvalid,
  input  wire logic              rready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp
);

  // ==========================================================
  // Declarations
  logic [7:0]        irqEn_q;
  logic [7:0]        rxCtrl_q;
  logic [7:0]        txCtrl_q;
  logic [7:0]        baudDiv_q;
  logic              overrun_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [7:0]        wByte_q;
  logic              wLane_q;

  logic              pinMeta_q;
  logic              pinSync_q;
  uard_rx_state_e    state_q;
  logic [3:0]        tickCnt_q;
  logic [3:0]        bitCnt_q;
  logic [8:0]        shift_q;
  logic              samp1_q;
  logic              samp2_q;

  logic              sampleTick;
  logic              rxRun;
  logic              nineBit;
  logic              addrDet;
  logic              vote;
  logic              atVote;
  logic [3:0]        lastBit;
  logic              frameDone;
  uard_word_s        newWord;
  logic              dropAddr;
  logic              overrunHit;
  logic              pushWord;
  uard_word_s        headWord;
  logic              bufFull;
  logic              bufEmpty;

  logic              awTake;
  logic              wTake;
  logic              arTake;
  logic              bTake;
  logic              rTake;
  logic              doWrite;
  logic              wrEn;
  logic              wrIrqEn;
  logic              wrRxCtrl;
  logic              wrTxCtrl;
  logic              wrBaud;
  logic              wrHit;
  logic              rdHit;
  logic              popBuf;
  logic [7:0]        irqFlagsRd;
  logic [7:0]        rxStatusRd;
  logic [7:0]        rdByte;
  logic [7:0]        newCtrl;

  // ==========================================================
  // Control decode
  // port on, async mode
  assign rxRun   = rxCtrl_q[BIT_PORT_EN] && rxCtrl_q[BIT_CONT_RX]
                   && !txCtrl_q[BIT_SYNC_MODE];
  assign nineBit = rxCtrl_q[BIT_NINE_EN];
  assign addrDet = rxCtrl_q[BIT_ADDR_DET];
  assign lastBit = nineBit ? BITS_NINE : BITS_EIGHT;

  // ==========================================================
  // Bit-rate tick source
  uard_baud_gen u_baud (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .run        (rxRun),
    .highBaud   (txCtrl_q[BIT_HIGH_BAUD]),
    .divisor    (baudDiv_q),
    .sampleTick (sampleTick)
  );

  // ==========================================================
  // Pin synchroniser
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta_q <= 1'b1;
      pinSync_q <= 1'b1;
    end else begin
      pinMeta_q <= receivePin;
      pinSync_q <= pinMeta_q;
    end
  end

  // ==========================================================
  // Data recovery
  // Majority of three centre samples rejects single-tick glitches
  assign atVote = sampleTick && (tickCnt_q == TICK_VOTE);
  assign vote   = (samp1_q & samp2_q) | (samp1_q & pinSync_q)
                  | (samp2_q & pinSync_q);

  // x16 sampling, one shift per bit
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= RX_IDLE;
      tickCnt_q <= 4'h0;
      bitCnt_q  <= 4'h0;
      shift_q   <= 9'h000;
      samp1_q   <= 1'b1;
      samp2_q   <= 1'b1;
    end else if (!rxRun) begin
      state_q   <= RX_IDLE;
      tickCnt_q <= 4'h0;
      bitCnt_q  <= 4'h0;
    end else if (sampleTick) begin
      tickCnt_q <= tickCnt_q + 4'h1;
      if (tickCnt_q == TICK_S1) begin
        samp1_q <= pinSync_q;
      end
      if (tickCnt_q == TICK_S2) begin
        samp2_q <= pinSync_q;
      end
      unique case (state_q)
        RX_IDLE: begin
          if (!pinSync_q) begin
            state_q   <= RX_START;
            tickCnt_q <= 4'h1;
          end
        end
        RX_START: begin
          if (atVote) begin
            state_q  <= vote ? RX_IDLE : RX_DATA;
            bitCnt_q <= 4'h0;
          end
        end
        RX_DATA: begin
          if (atVote) begin
            shift_q  <= {vote, shift_q[8:1]};
            bitCnt_q <= bitCnt_q + 4'h1;
            if (bitCnt_q + 4'h1 == lastBit) begin
              state_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (atVote) begin
            state_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Frame completion and buffer admission
  assign frameDone = rxRun && atVote && (state_q == RX_STOP);
  assign newWord.frameErr = !vote;
  assign newWord.ninth    = nineBit ? shift_q[8] : 1'b0;
  assign newWord.data     = nineBit ? shift_q[7:0] : shift_q[8:1];
  // drop frames with ninth bit zero
  assign dropAddr   = addrDet && nineBit && !newWord.ninth;
  assign overrunHit = frameDone && !overrun_q && !dropAddr && bufFull;
  assign pushWord   = frameDone && !overrun_q && !dropAddr && !bufFull;

  uard_rx_fifo u_fifo (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .push     (pushWord),
    .pushWord (newWord),
    .pop      (popBuf),
    .head     (headWord),
    .full     (bufFull),
    .empty    (bufEmpty)
  );

  // ==========================================================
  // Overrun flag
  // Set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      overrun_q <= 1'b0;
    end else if (overrunHit) begin
      overrun_q <= 1'b1;
    end else if (!rxCtrl_q[BIT_CONT_RX]) begin
      overrun_q <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt request
  // Lags the flag by one cycle so the port comes from a flop
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxIrq <= 1'b0;
    end else begin
      rxIrq <= !bufEmpty && irqEn_q[BIT_RX_FLAG];
    end
  end

  // ==========================================================
  // AXI4-Lite handshakes
  assign awTake  = awvalid && awready;
  assign wTake   = wvalid && wready;
  assign arTake  = arvalid && arready;
  assign bTake   = bvalid && bready;
  assign rTake   = rvalid && rready;
  assign doWrite = !awready && !wready && !bvalid;
  assign wrEn    = doWrite && wLane_q;

  assign wrIrqEn  = wrEn && (awAddr_q == ADDR_IRQ_ENABLES);
  assign wrRxCtrl = wrEn && (awAddr_q == ADDR_RX_STATUS);
  assign wrTxCtrl = wrEn && (awAddr_q == ADDR_TX_STATUS);
  assign wrBaud   = wrEn && (awAddr_q == ADDR_BAUD_DIV);
  assign wrHit    = (awAddr_q == ADDR_IRQ_FLAGS)
                    || (awAddr_q == ADDR_RX_STATUS)
                    || (awAddr_q == ADDR_RX_BUFFER)
                    || (awAddr_q == ADDR_IRQ_ENABLES)
                    || (awAddr_q == ADDR_TX_STATUS)
                    || (awAddr_q == ADDR_BAUD_DIV);
  assign newCtrl  = wByte_q & MASK_RX_CTRL;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      awAddr_q <= '0;
      wByte_q  <= 8'h00;
      wLane_q  <= 1'b0;
    end else begin
      if (awTake) begin
        awready  <= 1'b0;
        awAddr_q <= awaddr;
      end
      if (wTake) begin
        wready  <= 1'b0;
        wByte_q <= wdata[7:0];
        wLane_q <= wstrb[0];
      end
      if (doWrite) begin
        awready <= 1'b1;
        wready  <= 1'b1;
        bvalid  <= 1'b1;
        bresp   <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bTake) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Writable registers
  // Status bits of the receive register are hardware-owned
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqEn_q   <= RST_IRQ_ENABLES;
      rxCtrl_q  <= RST_RX_CTRL;
      txCtrl_q  <= RST_TX_STATUS & MASK_TX_STATUS;
      baudDiv_q <= RST_BAUD_DIV;
    end else begin
      if (wrIrqEn) begin
        irqEn_q <= wByte_q;
      end
      if (wrRxCtrl) begin
        rxCtrl_q <= newCtrl;
      end
      if (wrTxCtrl) begin
        txCtrl_q <= wByte_q & MASK_TX_STATUS;
      end
      if (wrBaud) begin
        baudDiv_q <= wByte_q;
      end
    end
  end

  // ==========================================================
  // Read path
  // flag follows buffer occupancy
  assign irqFlagsRd = 8'(!bufEmpty) << BIT_RX_FLAG;
  // head word bits shown until the buffer is read
  assign rxStatusRd = rxCtrl_q
                      | (8'(headWord.frameErr) << BIT_FRAME_ERR)
                      | (8'(overrun_q) << BIT_OVERRUN)
                      | (8'(headWord.ninth) << BIT_NINTH);
  assign rdHit  = (araddr == ADDR_IRQ_FLAGS)
                  || (araddr == ADDR_RX_STATUS)
                  || (araddr == ADDR_RX_BUFFER)
                  || (araddr == ADDR_IRQ_ENABLES)
                  || (araddr == ADDR_TX_STATUS)
                  || (araddr == ADDR_BAUD_DIV);
  assign rdByte =
    (araddr == ADDR_IRQ_FLAGS)   ? irqFlagsRd :
    (araddr == ADDR_RX_STATUS)   ? rxStatusRd :
    (araddr == ADDR_RX_BUFFER)   ? headWord.data :
    (araddr == ADDR_IRQ_ENABLES) ? irqEn_q :
    (araddr == ADDR_TX_STATUS)   ? (txCtrl_q | (8'h01 << BIT_TX_EMPTY)) :
    (araddr == ADDR_BAUD_DIV)    ? baudDiv_q : 8'h00;
  assign popBuf = arTake && (araddr == ADDR_RX_BUFFER);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arTake) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h00_0000, rdByte};
      rresp   <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rTake) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

endmodule // uard_receiver

`default_nettype wire

// file: verification/uard_receiver_chk.sv
// Checker: register bus timing and read-back fields of the receiver.
// Assumes it is bound into uard_receiver and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module uard_receiver_chk
  import uard_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              reset_n,
  // Write channels
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic              bvalid,
  input wire logic              bready,
  // Read channels
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic mapped;
  assign mapped = araddr inside {ADDR_IRQ_FLAGS, ADDR_RX_STATUS,
    ADDR_RX_BUFFER, ADDR_IRQ_ENABLES, ADDR_TX_STATUS, ADDR_BAUD_DIV};
  sequence wTake; awvalid && awready && wvalid && wready; endsequence
  sequence arTake; arvalid && arready; endsequence

  chk_b_latency: assert property (wTake |=> !bvalid ##1 bvalid)
    else $error("write response timing");
  chk_r_latency: assert property (arTake |=> rvalid)
    else $error("read data timing");
  chk_b_stands: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  chk_r_stands: assert property (rvalid && !rready |=> $stable(rdata))
    else $error("read data changed while waiting");
  chk_r_busy: assert property (rvalid |-> !arready)
    else $error("read address taken too early");
  chk_bad_addr: assert property (arTake |=> rresp == ($past(mapped) ?
    RESP_OKAY : RESP_SLVERR)) else $error("read response code");
  chk_flag_only: assert property (
    arTake ##0 araddr == ADDR_IRQ_FLAGS
    |=> (rdata[7:0] & 8'hDF) == 8'h00) else $error("flag bits");
  chk_tx_idle: assert property (arTake ##0 araddr == ADDR_TX_STATUS
    |=> rdata[1]) else $error("tx status bit 1");
endmodule // uard_receiver_chk

bind uard_receiver uard_receiver_chk chk_u (.*);
`default_nettype wire

// file: verification/uard_line_model.sv
// Remote asynchronous sender driving the receive pin.
// Assumes ref_clk is the receiver's clock; bit length given in cycles.
`timescale 1ns/100ps
`default_nettype none

module uard_line_model (
  // Clock
  input wire logic ref_clk,
  // Serial line
  output var logic receivePin
);
  // ==========================================================
  // Frame sender
  initial receivePin = 1'b1;
  // start low, LSB first, one stop
  task automatic send(input logic [8:0] d, input int nb,
                      input logic stopBit, input int bc);
    logic [10:0] fr;
    fr = (nb == 9) ? {stopBit, d, 1'b0} : {1'b1, stopBit, d[7:0], 1'b0};
    // Low stop only when a test asks for a broken frame
    for (int i = 0; i < nb + 2; i++) begin
      receivePin <= fr[i];
      repeat (bc) @(posedge ref_clk);
    end
    receivePin <= 1'b1;
    repeat (2 * bc) @(posedge ref_clk);
  endtask
endmodule // uard_line_model

`default_nettype wire

// file: verification/uard_receiver_tb.sv
// Self-checking bench for the asynchronous receiver and its registers.
// Assumes the line model and the bound checker are compiled with it.
`timescale 1ns/100ps
`default_nettype none

module uard_receiver_tb
  import uard_pkg::*;
();
  // ==========================================================
  // Bench
  logic ref_clk, reset_n, receivePin, rxIrq, awvalid, awready, wvalid;
  logic wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [2:0]        awprot, arprot;
  logic [1:0]        bresp, rresp, rs;
  int                mismatches, samples_checked;

  uard_receiver dut_u (.*);
  uard_line_model line_u (.ref_clk, .receivePin);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) mismatches++;
    if (g !== e) $display("Error at %0t: got %h want %h", $time, g, e);
  endtask

  // Bounded wait; a hang counts and ends the run
  task automatic step(inout int n);
    @(posedge ref_clk);
    n++;
    if (n > 200) begin
      chk8(8'hFF, 8'h00);
      summarize();
    end
  endtask

  task automatic summarize();
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      step(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    while (bvalid !== 1'b1) step(n);
    bready <= 1'b0;
    rs = bresp;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    int n = 0;
    @(posedge ref_clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do step(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do step(n); while (rvalid !== 1'b1);
    rready <= 1'b0;
    rs = rresp;
    chk8(rdata[7:0], e);
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_reset();
    logic [ADDR_W-1:0] ad [6];
    ad = '{ADDR_IRQ_FLAGS, ADDR_RX_STATUS, ADDR_RX_BUFFER,
      ADDR_IRQ_ENABLES, ADDR_TX_STATUS, ADDR_BAUD_DIV};
    for (int i = 0; i < 6; i++) rd(ad[i], (i == 4) ? 8'h02 : 8'h00);
    wr(12'h004, 8'h01);
    chk8({6'h00, rs}, {6'h00, RESP_SLVERR});
    rd(12'h004, 8'h00);
    chk8({6'h00, rs}, {6'h00, RESP_SLVERR});
    wr(ADDR_IRQ_FLAGS, 8'hFF);
    rd(ADDR_IRQ_FLAGS, 8'h00);
  endtask

  task automatic s_basic();
    wr(ADDR_TX_STATUS, 8'h04);
    wr(ADDR_RX_STATUS, 8'h90);
    chk8({6'h00, rs}, {6'h00, RESP_OKAY});
    line_u.send(9'h0A5, 8, 1'b1, 16);
    rd(ADDR_IRQ_FLAGS, 8'h20);
    chk8({7'h00, rxIrq}, 8'h00);
    wr(ADDR_IRQ_ENABLES, 8'h20);
    repeat (2) @(posedge ref_clk);
    chk8({7'h00, rxIrq}, 8'h01);
    rd(ADDR_RX_STATUS, 8'h90);
    rd(ADDR_RX_BUFFER, 8'hA5);
    rd(ADDR_IRQ_FLAGS, 8'h00);
    chk8({7'h00, rxIrq}, 8'h00);
  endtask

  task automatic s_fifo();
    line_u.send(9'h011, 8, 1'b1, 16);
    line_u.send(9'h022, 8, 1'b1, 16);
    line_u.send(9'h033, 8, 1'b1, 16);
    rd(ADDR_RX_STATUS, 8'h92);
    wr(ADDR_RX_STATUS, 8'h90);
    rd(ADDR_RX_STATUS, 8'h92);
    rd(ADDR_RX_BUFFER, 8'h11);
    rd(ADDR_RX_BUFFER, 8'h22);
    line_u.send(9'h044, 8, 1'b1, 16);
    rd(ADDR_IRQ_FLAGS, 8'h00);
    wr(ADDR_RX_STATUS, 8'h80);
    wr(ADDR_RX_STATUS, 8'h90);
    rd(ADDR_RX_STATUS, 8'h90);
  endtask

  task automatic s_nine();
    wr(ADDR_RX_STATUS, 8'hD0);
    line_u.send(9'h13C, 9, 1'b0, 16);
    line_u.send(9'h0C3, 9, 1'b1, 16);
    rd(ADDR_RX_STATUS, 8'hD5);
    rd(ADDR_RX_BUFFER, 8'h3C);
    rd(ADDR_RX_STATUS, 8'hD0);
    rd(ADDR_RX_BUFFER, 8'hC3);
    wr(ADDR_RX_STATUS, 8'hD8);
    line_u.send(9'h012, 9, 1'b1, 16);
    rd(ADDR_IRQ_FLAGS, 8'h00);
    line_u.send(9'h134, 9, 1'b1, 16);
    rd(ADDR_RX_STATUS, 8'hD9);
    rd(ADDR_RX_BUFFER, 8'h34);
    // Low rate, divisor one: eight cycles a tick, 128 a bit
    wr(ADDR_BAUD_DIV, 8'h01);
    rd(ADDR_BAUD_DIV, 8'h01);
    wr(ADDR_TX_STATUS, 8'h00);
    wr(ADDR_RX_STATUS, 8'h90);
    line_u.send(9'h05A, 8, 1'b1, 128);
    rd(ADDR_RX_BUFFER, 8'h5A);
    wr(ADDR_RX_STATUS, 8'h80);
    line_u.send(9'h077, 8, 1'b1, 128);
    rd(ADDR_IRQ_FLAGS, 8'h00);
  endtask

  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, awprot, arprot} = '0;
    {wstrb, mismatches, samples_checked} = {4'hF, 64'h0};
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    s_reset();
    s_basic();
    s_fifo();
    s_nine();
    summarize();
  end
endmodule // uard_receiver_tb

`default_nettype wire
